// File: design/hrpm_top.sv
// Read side of the parallel host port: source select and byte mux
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Read code comes from data bus bits 2:0 of that write.
// - Address lines pick the byte within the selected source.
// - Selected byte driven on data bus from read strobe falling edge.
// - Read address 111 returns status regardless of read code.
// - Codes 000/001/010 give I/Q, mag/phase, frequency bytes.
// - Code 100 gives 24-bit level detector in three bytes.
// - Code 101 addresses 000/001 give mantissa low, shift plus mantissa top.
// - Code 101 addresses 010/011 give unstabilised timing error bytes.
// - Status bits 6:4 report buffer depth in FIFO mode.
// - Status bit 3 high when buffer empty.
// - Status bit 2 high when buffer full.
// - Status bit 1 low at threshold or snapshot count reached.
// - Status bit 0 high when level detector integration is done.
// - Data and address captured on write strobe rising edge.
module hrpm_top (
  input  wire logic               MCLK,
  input  wire logic               RESET_N,
  input  wire logic [2:0]         A,
  input  wire logic [7:0]         C_IN,
  output logic      [7:0]         C_OUT,
  output logic                    C_OE_N,
  input  wire logic               WR_N,
  input  wire logic               RD_N,
  input  wire hrpm_pkg::hrpm_src_t  SRC,
  input  wire hrpm_pkg::hrpm_stat_t STAT,
  output logic      [2:0]         READ_CODE
);
  logic [2:0]  a_s;
  logic [7:0]  c_s;
  logic        wr_on_s;
  logic        rd_on_s;
  logic        wr_d_r;
  logic        rd_d_r;
  logic        wr_rise;
  logic        rd_fall;
  logic [2:0]  code_r;
  logic [7:0]  byte_nxt;
  logic [7:0]  dout_r;
  logic        oe_r;
  logic [6:0]  status_byte;

  // Strobes inverted so the reset value is the idle level
  hrpm_sync #(.W(13)) u_sync (
    .clk   (MCLK),
    .rst_n (RESET_N),
    .d     ({A, C_IN, ~WR_N, ~RD_N}),
    .q     ({a_s, c_s, wr_on_s, rd_on_s})
  );

  always_ff @(posedge MCLK) begin
    if (!RESET_N) begin
      wr_d_r <= 1'b0;
      rd_d_r <= 1'b0;
    end else begin
      wr_d_r <= wr_on_s;
      rd_d_r <= rd_on_s;
    end
  end

  assign wr_rise = ~wr_on_s & wr_d_r;
  assign rd_fall = rd_on_s & ~rd_d_r;

  // Read code register
  always_ff @(posedge MCLK) begin
    if (!RESET_N) begin
      code_r <= hrpm_pkg::CODE_RESET;
    end else if (wr_rise && a_s == hrpm_pkg::ADDR_SELECT) begin
      code_r <= c_s[2:0];
    end
  end

  assign READ_CODE = code_r;

  assign status_byte = {STAT.depth,
                        STAT.empty,
                        STAT.full,
                        STAT.buffer_threshold_n,
                        STAT.level_done};

  // Byte selection
  always_comb begin
    byte_nxt = 8'h00;
    if (a_s == hrpm_pkg::ADDR_STATUS) begin
      byte_nxt = {1'b0, status_byte};
    end else begin
      case (code_r)
        hrpm_pkg::CODE_IQ: begin
          case (a_s)
            3'h0: byte_nxt = SRC.i_val[7:0];
            3'h1: byte_nxt = SRC.i_val[15:8];
            3'h2: byte_nxt = SRC.q_val[7:0];
            3'h3: byte_nxt = SRC.q_val[15:8];
            default: byte_nxt = 8'h00;
          endcase
        end
        hrpm_pkg::CODE_MAGPHASE: begin
          case (a_s)
            3'h0: byte_nxt = SRC.mag_val[7:0];
            3'h1: byte_nxt = SRC.mag_val[15:8];
            3'h2: byte_nxt = SRC.phase_val[7:0];
            3'h3: byte_nxt = SRC.phase_val[15:8];
            default: byte_nxt = 8'h00;
          endcase
        end
        hrpm_pkg::CODE_FREQ: begin
          case (a_s)
            3'h0: byte_nxt = SRC.freq_val[7:0];
            3'h1: byte_nxt = SRC.freq_val[15:8];
            default: byte_nxt = 8'h00;
          endcase
        end
        hrpm_pkg::CODE_LEVEL: begin
          case (a_s)
            3'h0: byte_nxt = SRC.level_val[7:0];
            3'h1: byte_nxt = SRC.level_val[15:8];
            3'h2: byte_nxt = SRC.level_val[23:16];
            default: byte_nxt = 8'h00;
          endcase
        end
        hrpm_pkg::CODE_GAIN: begin
          case (a_s)
            3'h0: byte_nxt = SRC.gain_mant[7:0];
            3'h1: byte_nxt = {1'b0, SRC.gain_shift,
                              SRC.gain_mant[10:8]};
            3'h2: byte_nxt = SRC.timing_err[7:0];
            3'h3: byte_nxt = SRC.timing_err[15:8];
            default: byte_nxt = 8'h00;
          endcase
        end
        default: byte_nxt = 8'h00;
      endcase
    end
  end

  // Data latched at strobe fall, driven while strobe low
  always_ff @(posedge MCLK) begin
    if (!RESET_N) begin
      dout_r <= 8'h00;
    end else if (rd_fall) begin
      dout_r <= byte_nxt;
    end
  end

  always_ff @(posedge MCLK) begin
    if (!RESET_N) begin
      oe_r <= 1'b0;
    end else begin
      oe_r <= rd_on_s;
    end
  end

  assign C_OUT  = dout_r;
  assign C_OE_N = ~oe_r;

  // Assertions
  property p_code_capture;
    @(posedge MCLK) disable iff (!RESET_N)
      (wr_rise && a_s == hrpm_pkg::ADDR_SELECT) |=> code_r == $past(c_s[2:0]);
  endproperty
  a_code_capture: assert property (p_code_capture)
    else $error("read code not captured");

  property p_code_hold;
    @(posedge MCLK) disable iff (!RESET_N)
      !(wr_rise && a_s == hrpm_pkg::ADDR_SELECT) |=> $stable(code_r);
  endproperty
  a_code_hold: assert property (p_code_hold)
    else $error("read code changed without select write");

  property p_status;
    @(posedge MCLK) disable iff (!RESET_N)
      (rd_fall && a_s == hrpm_pkg::ADDR_STATUS)
        |=> dout_r == {1'b0, $past(status_byte)};
  endproperty
  a_status: assert property (p_status)
    else $error("status byte wrong");

  property p_level_msb;
    @(posedge MCLK) disable iff (!RESET_N)
      (rd_fall && code_r == hrpm_pkg::CODE_LEVEL && a_s == 3'h2)
        |=> dout_r == $past(SRC.level_val[23:16]);
  endproperty
  a_level_msb: assert property (p_level_msb)
    else $error("level detector msb wrong");

  property p_gain_hi;
    @(posedge MCLK) disable iff (!RESET_N)
      (rd_fall && code_r == hrpm_pkg::CODE_GAIN && a_s == 3'h1)
        |=> dout_r[6:0] == $past({SRC.gain_shift, SRC.gain_mant[10:8]});
  endproperty
  a_gain_hi: assert property (p_gain_hi)
    else $error("gain high byte wrong");

  property p_unused_zero;
    @(posedge MCLK) disable iff (!RESET_N)
      (rd_fall && a_s != hrpm_pkg::ADDR_STATUS
        && (code_r == 3'h3 || code_r == 3'h6 || code_r == 3'h7))
        |=> dout_r == 8'h00;
  endproperty
  a_unused_zero: assert property (p_unused_zero)
    else $error("unused code not zero");

  property p_drive;
    @(posedge MCLK) disable iff (!RESET_N)
      rd_fall |=> !C_OE_N;
  endproperty
  a_drive: assert property (p_drive)
    else $error("bus not driven after strobe fall");

  property p_iq;
    @(posedge MCLK) disable iff (!RESET_N)
      (rd_fall && code_r == hrpm_pkg::CODE_IQ && a_s == 3'h3)
        |=> dout_r == $past(SRC.q_val[15:8]);
  endproperty
  a_iq: assert property (p_iq)
    else $error("q msb wrong");

  c_select: cover property (@(posedge MCLK)
    wr_rise && a_s == hrpm_pkg::ADDR_SELECT);
  c_status: cover property (@(posedge MCLK)
    rd_fall && a_s == hrpm_pkg::ADDR_STATUS);
  c_level: cover property (@(posedge MCLK)
    rd_fall && code_r == hrpm_pkg::CODE_LEVEL);
endmodule
`default_nettype wire

// File: common/hrpm_pkg.sv
// Package: constants and carrier types for the host read port mux
package hrpm_pkg;
  localparam logic [2:0] ADDR_SELECT   = 3'h5;
  localparam logic [2:0] ADDR_STATUS   = 3'h7;
  localparam logic [2:0] CODE_IQ       = 3'h0;
  localparam logic [2:0] CODE_MAGPHASE = 3'h1;
  localparam logic [2:0] CODE_FREQ     = 3'h2;
  localparam logic [2:0] CODE_LEVEL    = 3'h4;
  localparam logic [2:0] CODE_GAIN     = 3'h5;
  localparam logic [2:0] CODE_RESET    = 3'h0;
  localparam int         STAT_DEPTH_HI = 6;
  localparam int         STAT_DEPTH_LO = 4;
  localparam int         STAT_EMPTY    = 3;
  localparam int         STAT_FULL     = 2;
  localparam int         STAT_THRESH_N = 1;
  localparam int         STAT_LEVEL_OK = 0;

  // Sources presented by the rest of the device
  typedef struct packed {
    logic [15:0] i_val;
    logic [15:0] q_val;
    logic [15:0] mag_val;
    logic [15:0] phase_val;
    logic [15:0] freq_val;
    logic [23:0] level_val;
    logic [10:0] gain_mant;
    logic [3:0]  gain_shift;
    logic [15:0] timing_err;
  } hrpm_src_t;

  // Buffer and detector status
  typedef struct packed {
    logic [2:0] depth;
    logic       empty;
    logic       full;
    logic       buffer_threshold_n;
    logic       level_done;
  } hrpm_stat_t;
endpackage

// File: design/hrpm_sync.sv
// Two-flop synchroniser, parameterised width
`timescale 1ns/1ps
`default_nettype none
module hrpm_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_r;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta_r <= '0;
      q      <= '0;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule
`default_nettype wire

// File: test/hrpm_host.sv
// Host processor model driving the parallel port
`timescale 1ns/1ps
`default_nettype none
module hrpm_host (
  input  wire logic       clk,
  input  wire logic [7:0] c_out,
  input  wire logic       c_oe_n,
  output logic      [2:0] a,
  output logic      [7:0] c_in,
  output logic            wr_n,
  output logic            rd_n
);
  initial begin
    a = 3'h0;
    c_in = 8'h00;
    wr_n = 1'b1;
    rd_n = 1'b1;
  end

  // Write cycle, strobe low 3 cycles, bus held past the rise
  task automatic wr(input logic [2:0] adr, input logic [7:0] dat);
    a <= adr;
    c_in <= dat;
    wr_n <= 1'b0;
    repeat (3) @(posedge clk);
    wr_n <= 1'b1;
    repeat (4) @(posedge clk);
    c_in <= ~dat;
    repeat (2) @(posedge clk);
  endtask

  // Read cycle, address settled before the strobe falls
  task automatic rd(input logic [2:0] adr, output logic [7:0] dat,
                    output logic oe_n);
    a <= adr;
    repeat (3) @(posedge clk);
    rd_n <= 1'b0;
    repeat (4) @(posedge clk);
    dat = c_out;
    oe_n = c_oe_n;
    rd_n <= 1'b1;
    repeat (5) @(posedge clk);
  endtask
endmodule
`default_nettype wire

// File: test/host_read_port_mux_tb.sv
// Testbench for the host read port mux
`timescale 1ns/1ps
`default_nettype none
module host_read_port_mux_tb;
  logic                 mclk;
  logic                 reset_n;
  logic [2:0]           a;
  logic [7:0]           c_in;
  logic [7:0]           c_out;
  logic                 c_oe_n;
  logic                 wr_n;
  logic                 rd_n;
  hrpm_pkg::hrpm_src_t  src;
  hrpm_pkg::hrpm_stat_t stat;
  logic [2:0]           read_code;
  logic [7:0]           d;
  logic                 oe_n;
  logic [2:0]           adr;
  int                   fail_count;
  int                   checks;
  int                   cycles;

  hrpm_top dut_u (.MCLK(mclk), .RESET_N(reset_n), .A(a), .C_IN(c_in),
    .C_OUT(c_out), .C_OE_N(c_oe_n), .WR_N(wr_n), .RD_N(rd_n), .SRC(src),
    .STAT(stat), .READ_CODE(read_code));
  hrpm_host host_u (.clk(mclk), .c_out(c_out), .c_oe_n(c_oe_n), .a(a),
    .c_in(c_in), .wr_n(wr_n), .rd_n(rd_n));

  always #5 mclk = ~mclk;

  // Expected byte for a code and address
  function automatic logic [7:0] exp_byte(input logic [2:0] code,
                                          input logic [2:0] ad);
    logic [15:0] w;
    if (ad == 3'h7) return {1'b0, stat};
    case (code)
      3'h0: w = ad[1] ? src.q_val : src.i_val;
      3'h1: w = ad[1] ? src.phase_val : src.mag_val;
      3'h2: w = ad[1] ? 16'h0000 : src.freq_val;
      3'h4: w = ad[1] ? {8'h00, src.level_val[23:16]} : src.level_val[15:0];
      3'h5: w = ad[1] ? src.timing_err : {1'b0, src.gain_shift, src.gain_mant};
      default: w = 16'h0000;
    endcase
    if (ad[2]) w = 16'h0000;
    return ad[0] ? w[15:8] : w[7:0];
  endfunction

  task automatic cmp(input string nm, input logic [7:0] ex,
                     input logic [7:0] got);
    checks++;
    if (got !== ex) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", nm, ex, got);
    end
  endtask

  task automatic tally_and_finish();
    if (fail_count == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      fail_count++;
      tally_and_finish();
    end
  end

  initial begin
    mclk = 1'b0;
    reset_n = 1'b0;
    fail_count = 0;
    checks = 0;
    cycles = 0;
    src = {16'h1122, 16'h3344, 16'h5566, 16'h7788, 16'h99AA, 24'h321AF5,
           11'h5A3, 4'hC, 16'hDEBF};
    stat = 7'h00;
    repeat (5) @(posedge mclk);
    reset_n <= 1'b1;
    repeat (2) @(posedge mclk);
    cmp("c_oe_n", 8'h01, {7'h00, c_oe_n});
    repeat (2) @(posedge mclk);
    cmp("read_code", 8'h00, {5'h00, read_code});
    for (int k = 0; k < 8; k++) begin
      stat <= {k[2:0], k[0], ~k[0], k[1], ~k[1]};
      host_u.wr(3'h5, {5'h1F, k[2:0]});
      cmp("read_code", {5'h00, k[2:0]}, {5'h00, read_code});
      for (int j = 0; j < 6; j++) begin
        adr = (j == 5) ? 3'h7 : j[2:0];
        host_u.rd(adr, d, oe_n);
        cmp("c_out", exp_byte(k[2:0], adr), d);
        cmp("c_oe_n", 8'h00, {7'h00, oe_n});
      end
      cmp("c_oe_n", 8'h01, {7'h00, c_oe_n});
    end
    host_u.wr(3'h3, 8'h02);
    cmp("read_code", 8'h07, {5'h00, read_code});
    stat <= 7'h55;
    host_u.rd(3'h7, d, oe_n);
    cmp("c_out", 8'h55, d);
    tally_and_finish();
  end
endmodule
`default_nettype wire
